// [banked_mem_map.svh]
/*
 * Address map, field positions and reset values of the banked data memory.
 * Assumes inclusion by its bare name from the package and the module.
 */
`ifndef BANKED_MEM_MAP_SVH
`define BANKED_MEM_MAP_SVH

// APB byte offsets of the block's registers
`define OFF_STATUS 12'h000
`define OFF_POINTER 12'h004
`define OFF_POWER 12'h008
`define OFF_BOREN 12'h00c
`define OFF_DATA 12'h400
`define OFF_DATA_END 12'h7fc
// Status register fields
`define STAT_BANK 5
`define STAT_RSV_LO 6
`define STAT_RSV_HI 7
// Power register fields
`define PWR_BROWN 0
`define PWR_POR 1
// Brown-out enable register field
`define ENABLE_BIT 0
// Data window: word offset bits of paddr, byte lane of the data
`define WIN_HI 8
`define WIN_LO 2
`define BYTE_HI 7
`define IDX_HI 6
// Data memory decode limits (7-bit offset within a bank)
`define SPECIAL_TOP 7'h1f
`define SMALL_LO 7'h40
`define LARGE_LO 7'h20
`define RAM_BASE 7'h20
`define B1_LO 7'h20
`define B1_HI 7'h3f
`define MIRROR_LO 7'h70
// Storage index ranges
`define IDX_B1 7'h60
`define RST_BYTE 8'h00
`define PSLVERR_NONE 1'b0

`endif

// [banked_mem_pkg.sv]
/*
 * Types shared by the banked data memory.
 * Assumes banked_mem_map.svh holds the numbers.
 */
`include "banked_mem_map.svh"

package banked_mem_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] index_t;
endpackage : banked_mem_pkg

// [banked_data_memory.sv]
/*
 * Banked data memory decode with reset-cause flags, reached over APB.
 * Holds the two-bank RAM, the status register with its bank select,
 * the indirect pointer, the power-on and brown-out cause flags and the
 * software brown-out enable, all in one packed state record.
 * Assumes the chip's power-on and brown-out detectors deliver one-cycle
 * pulses synchronous to ref_clk, an APB master on the core side that
 * keeps clkEn high while a transfer is open, and the map header beside.
 */
// Behaviour
// - Two banks; low 32 locations are special
// - Status bank bit selects bank zero or one
// - Small variant: bank 0 40h-7Fh is RAM
// - Large variant: 20h-7Fh and A0h-BFh RAM
// - Bank 1 F0h-FFh mirrors bank 0 70h-7Fh
// - Unimplemented locations read zero, ignore writes
// - RAM reachable directly and through pointer
// - Power-on flag reads 0 until software sets
// - Brown-out flag reads 0 until software sets
// - Brown-out flag reads 0 when detection off
// - Separate register at 00Ch holds software brown-out enable
// - Power bits 7-2 unimplemented, read zero
`timescale 1ns/1ps
`default_nettype none
`include "banked_mem_map.svh"

module banked_data_memory #(
    parameter bit LARGE = 1'b1,  // Larger memory variant
    parameter int DEPTH = 128    // Storage bytes, both banks together
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Reset cause pulses from the detectors
    input wire logic porEvent,
    input wire logic brownEvent,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status to chip
    output logic brownEnable,
    output logic bankSel
);

    // Whole state of the block; one record keeps reset and freeze simple
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;   // RAM bytes, both banks
        logic [7:0] status;           // Status register
        logic [7:0] pointer;          // Indirect pointer, full address
        logic porFlag;                // Power-on status, 0 = occurred
        logic brownFlag;              // Brown-out status, 0 = occurred
        logic brownEn;                // Brown-out enable
        logic [31:0] rdata;           // Read data, held until next read
        logic ready;                  // Access answered
    } state_s;

    // Registered state and its next value
    state_s st_ff;
    state_s nxt_st;

    // Decode result of a data access
    logic isData;                     // Address inside the data window
    logic indirect;                   // Pointer slot of the window
    logic [7:0] fullAddr;             // Bank bit plus bank offset
    logic hitOk;                      // Decoder says a byte backs it
    logic hit;                        // Backed and inside the window
    logic [7:0] mapIdx;               // Index as the decoder returns it
    banked_mem_pkg::index_t idx;      // Storage index
    banked_mem_pkg::byte_t rdByte;    // Byte read from the window
    logic access;                     // First access-phase cycle
    logic wr;                         // Write completing at this edge

    // Address decode: special area, mirror, bank 0 RAM, bank 1 RAM.
    // Returns the storage index; ok says a byte backs the location.
    // Bank 1 bytes sit above the bank 0 bytes, so one array serves both.
    function automatic logic [7:0] map_addr(input logic [7:0] a,
                                            output logic ok);
        logic [6:0] off;   // Offset within the bank
        logic [7:0] ix;    // Storage index, widened
        off = a[6:0];
        ix = 8'h00;
        ok = 1'b0;
        if (off <= `SPECIAL_TOP) begin
            // Special area is not backed by this RAM
            ok = 1'b0;
        end else if (a[7] && off >= `MIRROR_LO) begin
            // High window of bank 1 shares bank 0 bytes
            ok = LARGE || off >= `SMALL_LO;
            ix = {1'b0, 7'(off - `RAM_BASE)};
        end else if (!a[7]) begin
            // Bank 0 RAM from the variant's lower bound
            ok = LARGE ? (off >= `LARGE_LO) : (off >= `SMALL_LO);
            ix = {1'b0, 7'(off - `RAM_BASE)};
        end else if (LARGE && off >= `B1_LO && off <= `B1_HI) begin
            // Bank 1 RAM packed above the bank 0 bytes
            ok = 1'b1;
            ix = {1'b0, 7'(off - `B1_LO + `IDX_B1)};
        end
        // Anything else stays unbacked and reads zero
        return ix;
    endfunction : map_addr

    // Combinational next state: decode, read capture, write, events
    always_comb begin
        nxt_st = st_ff;
        hitOk = 1'b0;
        // First access-phase cycle; the answer follows one cycle later
        access = psel && penable && !st_ff.ready;
        // Writes land on the completing edge, when pready is seen high.
        // Limitation: a completion with clkEn low loses the write.
        wr = psel && penable && st_ff.ready && pwrite && pstrb[0];
        isData = paddr >= `OFF_DATA && paddr <= `OFF_DATA_END;
        indirect = paddr == `OFF_DATA;
        // Pointer slot uses the full pointer
        if (indirect) begin
            fullAddr = st_ff.pointer;
        end else begin
            // Direct slots take the bank from the status
            fullAddr = {st_ff.status[`STAT_BANK],
                        paddr[`WIN_HI:`WIN_LO]};
        end
        mapIdx = map_addr(fullAddr, hitOk);
        idx = mapIdx[`IDX_HI:0];
        hit = hitOk && isData;
        // Unbacked slots read zero
        rdByte = hit ? st_ff.mem[idx] : `RST_BYTE;
        nxt_st.ready = access;
        // Read data is captured at the access edge, shown with pready
        if (access && !pwrite) begin
            unique case (paddr)
                `OFF_STATUS: nxt_st.rdata = {24'h0, st_ff.status};
                `OFF_POINTER: nxt_st.rdata = {24'h0, st_ff.pointer};
                // Upper bits zero; brown-out masked when off
                `OFF_POWER: nxt_st.rdata = {30'h0, st_ff.porFlag,
                    st_ff.brownFlag & st_ff.brownEn};
                `OFF_BOREN: nxt_st.rdata = {31'h0, st_ff.brownEn};
                // Data window or unmapped: zero unless backed
                default: nxt_st.rdata = {24'h0, rdByte};
            endcase
        end
        // Software writes, byte lane 0 only
        if (wr) begin
            unique case (paddr)
                // Reserved bits are stored as written
                `OFF_STATUS: nxt_st.status = pwdata[`BYTE_HI:0];
                `OFF_POINTER: nxt_st.pointer = pwdata[`BYTE_HI:0];
                `OFF_POWER: begin
                    nxt_st.porFlag = pwdata[`PWR_POR];
                    nxt_st.brownFlag = pwdata[`PWR_BROWN];
                end
                // Software enable of brown-out detection
                `OFF_BOREN: nxt_st.brownEn = pwdata[`ENABLE_BIT];
                default: begin
                    // Unbacked slots keep nothing
                    if (hit) begin
                        nxt_st.mem[idx] = pwdata[`BYTE_HI:0];
                    end
                end
            endcase
        end
        // Reset events win over software writes
        if (brownEvent) begin
            nxt_st.brownFlag = 1'b0;
        end
        // Power-on clears both causes; brown-out left power-on alone
        if (porEvent) begin
            nxt_st.porFlag = 1'b0;
            nxt_st.brownFlag = 1'b0;
        end
    end

    // State register; clkEn freezes everything
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // All zero, which reads as "reset occurred" for both flags
            st_ff <= '0;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops; pslverr tied low
    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = `PSLVERR_NONE;
    assign brownEnable = st_ff.brownEn;
    assign bankSel = st_ff.status[`STAT_BANK];

    // Power-on pulse clears the flag next cycle
    por_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && porEvent |=> !st_ff.porFlag)
        else $error("power-on flag not cleared");
    // Brown-out pulse alone keeps power-on flag
    brown_keeps_por_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clkEn && brownEvent && !porEvent && !wr |=>
        st_ff.porFlag == $past(st_ff.porFlag))
        else $error("brown-out disturbed power-on flag");
    // Brown-out flag masked by disable
    brown_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(pready) && $past(paddr) == `OFF_POWER && !$past(pwrite)
        && !$past(st_ff.brownEn) |-> prdata[`PWR_BROWN] == 1'b0)
        else $error("brown-out flag visible while off");
    // Upper power bits zero
    power_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(pready) && $past(paddr) == `OFF_POWER && !$past(pwrite)
        |-> prdata[31:2] == 30'h0)
        else $error("power upper bits nonzero");
    // Special area of a data window reads zero
    special_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && access && !pwrite && isData && !indirect
        && paddr[`WIN_HI:`WIN_LO] <= `SPECIAL_TOP |=> prdata == 32'h0)
        else $error("special slot returned data");
    // Reads answer the cycle after the access
    apb_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && access |=> pready ##1 !pready || !clkEn)
        else $error("access not answered");
    // Bank bit follows status writes
    bank_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && wr && paddr == `OFF_STATUS |=>
        bankSel == $past(pwdata[`STAT_BANK]))
        else $error("bank select not written");
    // Mirror slot returns bank 0 contents
    mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && access && !pwrite && indirect && st_ff.pointer[7]
        && st_ff.pointer[6:0] >= `MIRROR_LO |=>
        prdata[7:0] == $past(st_ff.mem[st_ff.pointer[6:0] - `RAM_BASE]))
        else $error("mirror mismatch");
    // Brown-out pulse clears its flag
    brown_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && brownEvent |=> !st_ff.brownFlag)
        else $error("brown-out flag not cleared");
    // Unbacked data slots keep no written value
    unbacked_hold_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clkEn && wr && isData && !hit |=>
        st_ff.mem == $past(st_ff.mem))
        else $error("unbacked slot stored data");
    // Power-on flag takes a software write when no event
    por_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && wr && paddr == `OFF_POWER && !porEvent |=>
        st_ff.porFlag == $past(pwdata[`PWR_POR]))
        else $error("power-on flag not written");
    // Enable output follows its register write
    enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && wr && paddr == `OFF_BOREN |=>
        brownEnable == $past(pwdata[`ENABLE_BIT]))
        else $error("brown-out enable not written");
    // Frozen clock enable holds every bit of state
    freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !clkEn |=> st_ff == $past(st_ff))
        else $error("state moved while frozen");
    // Writes are answered exactly one cycle after the access
    write_answer_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clkEn && access && pwrite |=> pready)
        else $error("write not answered");

endmodule : banked_data_memory
`default_nettype wire

// [apb_cpu_model.sv]
/* CPU-side APB master model issuing the core's data accesses.
   Assumes one clock; the bench calls xfer by hierarchical name. */
`timescale 1ns/1ps
`default_nettype none
module apb_cpu_model (
    // Clock
    input wire logic ref_clk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Answer
    input wire logic pready,
    output logic timedOut
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
        timedOut = 1'b0;
    end
    // Setup, then access held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) timedOut <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data flips so a stale value is never mistaken
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_cpu_model
`default_nettype wire

// [banked_data_memory_reset_flags_tb.sv]
/* Self-checking bench for the banked data memory and reset flags.
   Assumes apb_cpu_model drives the APB side; the large variant. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin numErrors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module banked_data_memory_reset_flags_tb;
    logic ref_clk, rst_n, clkEn, porEvent, brownEvent;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, expW;
    logic [3:0] pstrb;
    logic pready, pslverr, brownEnable, bankSel, timedOut;
    logic [7:0] v1, v2;
    logic [31:0] expQ[$]; // Expected read data in issue order
    integer seed, numErrors, nTests;
    banked_data_memory #(.LARGE(1'b1), .DEPTH(128)) i_dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .clkEn(clkEn), .porEvent(porEvent),
        .brownEvent(brownEvent), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownEnable(brownEnable), .bankSel(bankSel));
    apb_cpu_model i_cpu (.ref_clk(ref_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .timedOut(timedOut));
    // Clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Data window address of a bank offset
    function automatic logic [11:0] da(input logic [6:0] o);
        return {3'b010, o, 2'b00};
    endfunction : da
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b1, a, {24'h000000, d});
    endtask : wr
    // Note the expectation first, the monitor judges it
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expQ.push_back({24'h000000, e});
        i_cpu.xfer(1'b0, a, 32'h00000000);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0 && expQ.size() == 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Read monitor: oldest note against each answer
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0) begin
            expW = expQ.pop_front();
            `CHK("prdata", expW, prdata)
        end
    end
    // A stuck bus ends the run
    always @(posedge timedOut) begin
        numErrors++;
        tally_and_finish;
    end
    initial begin
        numErrors = 0;
        nTests = 0;
        seed = 32'h82f0;
        rst_n = 1'b0;
        clkEn = 1'b1;
        porEvent = 1'b0;
        brownEvent = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(12'h008, 8'h00);
        wr(12'h00c, 8'h01);
        wr(12'h008, 8'hff);
        rd(12'h008, 8'h03);
        brownEvent <= 1'b1;
        @(posedge ref_clk);
        brownEvent <= 1'b0;
        rd(12'h008, 8'h02);
        // Frozen enable: a brown-out pulse must not reach the flag
        wr(12'h008, 8'h03);
        clkEn <= 1'b0;
        brownEvent <= 1'b1;
        @(posedge ref_clk);
        brownEvent <= 1'b0;
        @(posedge ref_clk);
        clkEn <= 1'b1;
        rd(12'h008, 8'h03);
        wr(12'h00c, 8'h00);
        rd(12'h008, 8'h02);
        `CHK("brownEnable", 1'b0, brownEnable)
        porEvent <= 1'b1;
        @(posedge ref_clk);
        porEvent <= 1'b0;
        wr(12'h00c, 8'h01);
        rd(12'h008, 8'h00);
        $display("test power flags done");
        v1 = 8'($random(seed));
        v2 = 8'($random(seed));
        wr(12'h000, 8'h00);
        wr(da(7'h70), v1);
        wr(da(7'h20), v2);
        wr(da(7'h10), v2);
        rd(da(7'h10), 8'h00);
        wr(12'h000, 8'h20);
        // Write lands on the completing edge; look one edge later
        @(posedge ref_clk);
        `CHK("bankSel", 1'b1, bankSel)
        rd(da(7'h70), v1);
        wr(da(7'h20), ~v2);
        rd(da(7'h20), ~v2);
        wr(da(7'h40), v1);
        rd(da(7'h40), 8'h00);
        wr(12'h004, 8'h20);
        rd(12'h400, v2);
        wr(12'h004, 8'hf0);
        rd(12'h400, v1);
        wr(12'h000, 8'h00);
        rd(da(7'h20), v2);
        rd(12'h100, 8'h00);
        $display("test banks done");
        @(posedge ref_clk);
        tally_and_finish;
    end
endmodule : banked_data_memory_reset_flags_tb
`default_nettype wire
